// file: rtl/mdb_consts.svh
// constants of the module disable bank: offsets, write masks, reset values, field positions
// assumes a 12-bit byte address on the register port
`ifndef MDB_CONSTS_SVH
`define MDB_CONSTS_SVH

`define MDB_ADDR_W 12
`define MDB_DATA_W 8
`define MDB_NUM_REGS 5
`define MDB_N_PERIPH 34

`define MDB_OFF_CTRL_1 12'h064
`define MDB_OFF_CTRL_2 12'h065
`define MDB_OFF_CTRL_3 12'h066
`define MDB_OFF_CTRL_4 12'h067
`define MDB_OFF_CTRL_5 12'h068

`define MDB_IDX_CTRL_1 3'h0
`define MDB_IDX_CTRL_2 3'h1
`define MDB_IDX_CTRL_3 3'h2
`define MDB_IDX_CTRL_4 3'h3
`define MDB_IDX_CTRL_5 3'h4

`define MDB_RST_VAL 8'h00
`define MDB_WMASK_CTRL_1 8'h7F
`define MDB_WMASK_CTRL_2 8'hFF
`define MDB_WMASK_CTRL_3 8'hFF
`define MDB_WMASK_CTRL_4 8'hFF
`define MDB_WMASK_CTRL_5 8'h07

`define MDB_BIT_ZERO_CROSS 6
`define MDB_BIT_SIG_MEASURE 5
`define MDB_BIT_CAPCMP 7
`define MDB_BIT_WAVEGEN 6
`define MDB_BIT_SIGMOD 5
`define MDB_BIT_NCO 4
`define MDB_BIT_CLKTUNE 3
`define MDB_BIT_CONV_A 2
`define MDB_BIT_ADC 1
`define MDB_BIT_CMP_TWO 0
`define MDB_BIT_SPI_TWO 5
`define MDB_BIT_SPI_ONE 4
`define MDB_BIT_I2C_ONE 3
`define MDB_BIT_PWM_THREE 2
`define MDB_BIT_PWM_TWO 1
`define MDB_BIT_PWM_ONE 0
`define MDB_BIT_SERIAL_THREE 0
`define MDB_BIT_OP_AMP 2
`define MDB_BIT_CONV_B 1
`define MDB_BIT_DMA_FOUR 0

`endif

// file: rtl/mdb_pkg.sv
// types of the module disable bank
// widths come from mdb_consts.svh
`include "mdb_consts.svh"

package mdb_pkg;

  typedef logic [`MDB_ADDR_W-1:0] mdb_addr_t;
  typedef logic [`MDB_DATA_W-1:0] mdb_byte_t;

  // one register-port request
  typedef struct packed {
    logic wr;
    logic rd;
    mdb_addr_t addr;
    mdb_byte_t wdata;
  } mdb_req_t;

  // named disable outputs
  typedef struct packed {
    logic zero_cross_off;
    logic signal_measure_timer_off;
    logic [4:0] timer_n_off;
    logic capture_compare_off;
    logic waveform_gen_off;
    logic signal_modulator_off;
    logic num_ctrl_osc_off;
    logic clock_tuning_off;
    logic converter_a_off;
    logic adc_off;
    logic comparator_two_off;
    logic [1:0] serial_port_n_off;
    logic spi_two_off;
    logic spi_one_off;
    logic i2c_one_off;
    logic pulse_mod_three_off;
    logic pulse_mod_two_off;
    logic pulse_mod_one_off;
    logic [3:0] dma_channel_n_off;
    logic [3:0] logic_cell_n_off;
    logic serial_port_three_off;
    logic op_amp_off;
    logic converter_b_off;
  } mdb_off_t;

  // peripheral register access coming from the peripheral side
  typedef struct packed {
    logic we;
    mdb_byte_t rdata;
  } mdb_sfr_t;

  // gated controls toward one peripheral
  typedef struct packed {
    logic rst;
    logic out_en;
    logic we;
    mdb_byte_t rdata;
  } mdb_gate_t;

endpackage : mdb_pkg

// file: rtl/mdb_gate.sv
// per-peripheral gate: reset hold, output enable, register write block and read masking
// assumes the disable level comes from the bank flip-flops in the same clock domain
`timescale 1ns/100ps
`include "mdb_consts.svh"

module mdb_gate
  import mdb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // disable level
  input wire logic off,
  // peripheral side
  input wire mdb_sfr_t sfr,
  output mdb_gate_t gate
);

  logic hold_r;
  logic blocked;

  // held in reset from the cycle after disable to the cycle after re-enable; system reset sets the hold until the first clock edge after its release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_r <= 1'b1;
    end else begin
      hold_r <= off;
    end
  end

  // access stays blocked until the held reset has been released
  assign blocked = off | hold_r;
  assign gate.rst = hold_r;
  assign gate.out_en = ~off;
  assign gate.we = sfr.we & ~blocked;
  assign gate.rdata = blocked ? `MDB_RST_VAL : sfr.rdata;

  AST_GATE_HOLD: assert property (@(posedge mclk) disable iff (rst)
    off |=> gate.rst)
    else $error("disabled peripheral not held in reset");

  AST_GATE_BLOCK: assert property (@(posedge mclk) disable iff (rst)
    off |-> (!gate.we && gate.rdata == 8'h00 && !gate.out_en))
    else $error("disabled peripheral still reachable");

  AST_GATE_RELEASE: assert property (@(posedge mclk) disable iff (rst)
    $fell(off) ##1 !off |-> (!gate.rst && gate.out_en))
    else $error("re-enabled peripheral not released from reset");

endmodule : mdb_gate

// file: rtl/mdb_bank.sv
// module disable bank: five control registers whose set bits switch off peripherals
// assumes one-cycle write and read strobes on a plain register port, read data the cycle after
`timescale 1ns/100ps
`include "mdb_consts.svh"

// How it works
// - one means off, zero means on
// - second register bit 6 kills zero-cross
// - zero-cross off also depends on configuration
// - second register bit 5 kills measure timer
// - bits 4..0 kill timers 4..0
// - third register: compare, wavegen, modulator, converters
// - fourth register: serial, SPI, I2C, PWM
// - fifth register: DMA, logic cells, serial three
// - sixth register: op-amp, converter B, DMA four
// - third to fifth fully read/write, reset zero
// - any system reset clears every bit
// - disabled peripheral held reset, blocked, reads zero
// - re-enabled peripheral restarts from reset values
module mdb_bank
  import mdb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire mdb_req_t req,
  output mdb_byte_t rdata,
  // configuration: keeps the zero-cross detector on whatever software writes
  input wire logic zcd_always_on,
  // named disable levels
  output mdb_off_t off,
  // per-peripheral access gating, index order low register low bit first
  input wire mdb_sfr_t [`MDB_N_PERIPH-1:0] sfr,
  output mdb_gate_t [`MDB_N_PERIPH-1:0] gate
);

  localparam mdb_byte_t WMASK [0:`MDB_NUM_REGS-1] = '{
    `MDB_WMASK_CTRL_1,
    `MDB_WMASK_CTRL_2,
    `MDB_WMASK_CTRL_3,
    `MDB_WMASK_CTRL_4,
    `MDB_WMASK_CTRL_5
  };

  mdb_byte_t ctrl_r [0:`MDB_NUM_REGS-1];
  mdb_byte_t rdata_r;
  mdb_byte_t rdata_nxt;
  mdb_addr_t rel;
  logic [2:0] idx;
  logic hit;
  logic wr_hit;
  logic rd_hit;
  mdb_byte_t wr_val;
  mdb_byte_t rd_val;
  mdb_byte_t ctrl_1;
  mdb_byte_t ctrl_2;
  mdb_byte_t ctrl_3;
  mdb_byte_t ctrl_4;
  mdb_byte_t ctrl_5;
  logic zero_cross_eff;
  logic [`MDB_N_PERIPH-1:0] off_vec;

  // address decode
  assign rel = req.addr - `MDB_OFF_CTRL_1;
  assign hit = (rel < mdb_addr_t'(`MDB_NUM_REGS));
  assign idx = rel[2:0];
  assign wr_hit = req.wr & hit;
  assign rd_hit = req.rd & hit;
  // bits without a function are dropped on the way in
  assign wr_val = req.wdata & WMASK[idx];
  assign rd_val = hit ? ctrl_r[idx] : `MDB_RST_VAL;
  // read data stand only in the cycle after the strobe
  assign rdata_nxt = req.rd ? rd_val : `MDB_RST_VAL;

  // register storage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `MDB_NUM_REGS; i++) begin
        ctrl_r[i] <= `MDB_RST_VAL;
      end
    end else if (wr_hit) begin
      ctrl_r[idx] <= wr_val;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= `MDB_RST_VAL;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  assign ctrl_1 = ctrl_r[`MDB_IDX_CTRL_1];
  assign ctrl_2 = ctrl_r[`MDB_IDX_CTRL_2];
  assign ctrl_3 = ctrl_r[`MDB_IDX_CTRL_3];
  assign ctrl_4 = ctrl_r[`MDB_IDX_CTRL_4];
  assign ctrl_5 = ctrl_r[`MDB_IDX_CTRL_5];

  // configuration override of the zero-cross detector
  assign zero_cross_eff = ctrl_1[`MDB_BIT_ZERO_CROSS] & ~zcd_always_on;

  // named outputs
  assign off.zero_cross_off = zero_cross_eff;
  assign off.signal_measure_timer_off = ctrl_1[`MDB_BIT_SIG_MEASURE];
  assign off.timer_n_off = ctrl_1[4:0];
  assign off.capture_compare_off = ctrl_2[`MDB_BIT_CAPCMP];
  assign off.waveform_gen_off = ctrl_2[`MDB_BIT_WAVEGEN];
  assign off.signal_modulator_off = ctrl_2[`MDB_BIT_SIGMOD];
  assign off.num_ctrl_osc_off = ctrl_2[`MDB_BIT_NCO];
  assign off.clock_tuning_off = ctrl_2[`MDB_BIT_CLKTUNE];
  assign off.converter_a_off = ctrl_2[`MDB_BIT_CONV_A];
  assign off.adc_off = ctrl_2[`MDB_BIT_ADC];
  assign off.comparator_two_off = ctrl_2[`MDB_BIT_CMP_TWO];
  assign off.serial_port_n_off = ctrl_3[7:6];
  assign off.spi_two_off = ctrl_3[`MDB_BIT_SPI_TWO];
  assign off.spi_one_off = ctrl_3[`MDB_BIT_SPI_ONE];
  assign off.i2c_one_off = ctrl_3[`MDB_BIT_I2C_ONE];
  assign off.pulse_mod_three_off = ctrl_3[`MDB_BIT_PWM_THREE];
  assign off.pulse_mod_two_off = ctrl_3[`MDB_BIT_PWM_TWO];
  assign off.pulse_mod_one_off = ctrl_3[`MDB_BIT_PWM_ONE];
  // channel four lives in the sixth register, channels three to one here
  assign off.dma_channel_n_off = {ctrl_5[`MDB_BIT_DMA_FOUR], ctrl_4[7:5]};
  assign off.logic_cell_n_off = ctrl_4[4:1];
  assign off.serial_port_three_off = ctrl_4[`MDB_BIT_SERIAL_THREE];
  assign off.op_amp_off = ctrl_5[`MDB_BIT_OP_AMP];
  assign off.converter_b_off = ctrl_5[`MDB_BIT_CONV_B];

  // flat disable vector feeding the gates
  assign off_vec = {ctrl_5[2:0], ctrl_4, ctrl_3, ctrl_2, zero_cross_eff, ctrl_1[5:0]};

  genvar g;
  generate
    for (g = 0; g < `MDB_N_PERIPH; g++) begin : g_gate
      mdb_gate u_gate (
        .mclk(mclk),
        .rst(rst),
        .off(off_vec[g]),
        .sfr(sfr[g]),
        .gate(gate[g])
      );
    end
  endgenerate

  // software keeps off a re-enabled peripheral for two cycles; the gate blocks one cycle itself

  // checks
  sequence seq_write_to(mdb_addr_t a);
    req.wr && req.addr == a;
  endsequence

  sequence seq_read_of(mdb_addr_t a);
    req.rd && req.addr == a;
  endsequence

  sequence seq_reset_release;
    $past(rst);
  endsequence

  property prop_store(mdb_addr_t a, int i, mdb_byte_t m);
    @(posedge mclk) disable iff (rst)
      seq_write_to(a) |=> (ctrl_r[i] == ($past(req.wdata) & m));
  endproperty

  property prop_readback(mdb_addr_t a, int i);
    @(posedge mclk) disable iff (rst)
      seq_read_of(a) |=> (rdata == $past(ctrl_r[i])) ##1 (rdata == 8'h00 || $past(req.rd));
  endproperty

  AST_RESET_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    seq_reset_release |-> (ctrl_1 == 8'h00 && ctrl_2 == 8'h00 && ctrl_3 == 8'h00
      && ctrl_4 == 8'h00 && ctrl_5 == 8'h00 && off == '0))
    else $error("bank not cleared by reset");

  AST_STORE_CTRL_1: assert property (prop_store(12'h064, 0, 8'h7F))
    else $error("second register write not stored");

  AST_STORE_CTRL_2: assert property (prop_store(12'h065, 1, 8'hFF))
    else $error("third register write not stored");

  AST_STORE_CTRL_4: assert property (prop_store(12'h067, 3, 8'hFF))
    else $error("fifth register write not stored");

  AST_STORE_CTRL_5: assert property (prop_store(12'h068, 4, 8'h07))
    else $error("sixth register write wrong");

  AST_READ_CTRL_3: assert property (prop_readback(12'h066, 2))
    else $error("fourth register read wrong");

  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (rst)
    seq_read_of(12'h068) |=> (rdata[7:3] == 5'h00))
    else $error("sixth register upper bits not zero");

  AST_ZERO_CROSS: assert property (@(posedge mclk) disable iff (rst)
    seq_write_to(12'h064) ##1 (!zcd_always_on && !req.wr)
      |-> off.zero_cross_off == $past(req.wdata[6], 1))
    else $error("zero-cross disable not following its bit");

  AST_ZERO_CROSS_CFG: assert property (@(posedge mclk) disable iff (rst)
    zcd_always_on |-> !off.zero_cross_off && gate[6].out_en ##1 (!zcd_always_on || !gate[6].rst))
    else $error("zero-cross disabled against configuration");

  AST_TIMERS: assert property (@(posedge mclk) disable iff (rst)
    seq_write_to(12'h064) |=> off.timer_n_off == $past(req.wdata[4:0])
      && off.signal_measure_timer_off == $past(req.wdata[5]))
    else $error("timer disables not following their bits");

  AST_MAP_CTRL_2: assert property (@(posedge mclk) disable iff (rst)
    seq_write_to(12'h065) |=> {off.capture_compare_off, off.waveform_gen_off, off.signal_modulator_off,
      off.num_ctrl_osc_off, off.clock_tuning_off, off.converter_a_off, off.adc_off,
      off.comparator_two_off} == $past(req.wdata))
    else $error("third register mapping wrong");

  AST_MAP_CTRL_3: assert property (@(posedge mclk) disable iff (rst)
    seq_write_to(12'h066) |=> {off.serial_port_n_off, off.spi_two_off, off.spi_one_off, off.i2c_one_off,
      off.pulse_mod_three_off, off.pulse_mod_two_off, off.pulse_mod_one_off} == $past(req.wdata))
    else $error("fourth register mapping wrong");

  AST_MAP_CTRL_4: assert property (@(posedge mclk) disable iff (rst)
    seq_write_to(12'h067) |=> {off.dma_channel_n_off[2:0], off.logic_cell_n_off,
      off.serial_port_three_off} == $past(req.wdata))
    else $error("fifth register mapping wrong");

  AST_MAP_CTRL_5: assert property (@(posedge mclk) disable iff (rst)
    seq_write_to(12'h068) |=> {off.op_amp_off, off.converter_b_off, off.dma_channel_n_off[3]}
      == $past(req.wdata[2:0]))
    else $error("sixth register mapping wrong");

  AST_GATE_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
    off.adc_off [*2] |-> gate[8].rst && !gate[8].we && gate[8].rdata == 8'h00)
    else $error("converter not held while disabled");

  AST_UNMAPPED: assert property (@(posedge mclk) disable iff (rst)
    (req.rd && (req.addr < 12'h064 || req.addr > 12'h068)) |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // further register port checks
  AST_STORE_CTRL_3: assert property (prop_store(12'h066, 2, 8'hFF))
    else $error("fourth register write not stored");

  AST_READ_CTRL_1: assert property (prop_readback(12'h064, 0))
    else $error("second register read wrong");

  AST_READ_CTRL_2: assert property (prop_readback(12'h065, 1))
    else $error("third register read wrong");

  AST_READ_CTRL_4: assert property (prop_readback(12'h067, 3))
    else $error("fifth register read wrong");

  AST_READ_CTRL_5: assert property (prop_readback(12'h068, 4))
    else $error("sixth register read wrong");

  AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (rst)
    !req.rd |=> rdata == 8'h00)
    else $error("read data stand without a read");

  AST_UNMAPPED_WRITE: assert property (@(posedge mclk) disable iff (rst)
    (req.wr && (req.addr < 12'h064 || req.addr > 12'h068)) |=> $stable(ctrl_1) && $stable(ctrl_2)
      && $stable(ctrl_3) && $stable(ctrl_4) && $stable(ctrl_5))
    else $error("unmapped write changed the bank");

  AST_READ_NO_STORE: assert property (@(posedge mclk) disable iff (rst)
    req.rd |=> $stable(ctrl_1) && $stable(ctrl_2) && $stable(ctrl_3) && $stable(ctrl_4)
      && $stable(ctrl_5))
    else $error("read changed the bank");

  AST_OFF_STEADY: assert property (@(posedge mclk) disable iff (rst)
    !req.wr ##1 $stable(zcd_always_on) |-> $stable(off))
    else $error("disable levels moved without a write");

  // reserved bits never hold a one
  AST_CTRL_1_TOP: assert property (@(posedge mclk) disable iff (rst)
    ctrl_1[7] == 1'b0)
    else $error("second register bit 7 stored");

  AST_CTRL_5_TOP: assert property (@(posedge mclk) disable iff (rst)
    ctrl_5[7:3] == 5'h00)
    else $error("sixth register upper bits stored");

  // gate checks
  AST_RESET_GATES: assert property (@(posedge mclk) disable iff (rst)
    seq_reset_release |-> rdata == 8'h00 && gate[0].rst && gate[33].rst)
    else $error("gates not held at reset release");

  AST_ZERO_CROSS_GATE: assert property (@(posedge mclk) disable iff (rst)
    off.zero_cross_off |-> !gate[6].out_en && !gate[6].we)
    else $error("zero-cross gate open while disabled");

  AST_CONV_B_GATE: assert property (@(posedge mclk) disable iff (rst)
    off.converter_b_off [*2] |-> gate[32].rst && gate[32].rdata == 8'h00)
    else $error("second converter not held while disabled");

  AST_TIMER_RELEASE: assert property (@(posedge mclk) disable iff (rst)
    $fell(off.timer_n_off[0]) ##1 !off.timer_n_off[0] |-> !gate[0].rst && gate[0].out_en)
    else $error("re-enabled timer not released");

  AST_GATE_INDEX: assert property (@(posedge mclk) disable iff (rst)
    gate[0].out_en == !off.timer_n_off[0] && gate[5].out_en == !off.signal_measure_timer_off
      && gate[14].out_en == !off.capture_compare_off && gate[22].out_en == !off.serial_port_n_off[1]
      && gate[30].out_en == !off.dma_channel_n_off[2] && gate[31].out_en == !off.dma_channel_n_off[3]
      && gate[33].out_en == !off.op_amp_off)
    else $error("gate index does not match its disable bit");

endmodule : mdb_bank

// file: tb/tb_mdb_bank.sv
// self-checking bench of the module disable bank: register port, disable levels, peripheral gates
// assumes the bank alone under test, bench drives every input at the rising edge by non-blocking assignment
`timescale 1ns/100ps

module tb_mdb_bank
  import mdb_pkg::*;
;
  logic mclk = 1'b0;
  logic rst;
  mdb_req_t req;
  mdb_byte_t rdata;
  logic zcd_always_on;
  mdb_off_t off;
  mdb_sfr_t [33:0] sfr;
  mdb_gate_t [33:0] gate;

  // bench mirror of the bank
  logic [7:0] m [5];
  mdb_byte_t exp_rd;
  logic [33:0] pv;
  logic [33:0] pv2;
  logic [15:0] s;
  logic [15:0] s_sfr = 16'h0022;
  int error_cnt;
  int n_tests;

  mdb_bank DUT (
    .mclk(mclk),
    .rst(rst),
    .req(req),
    .rdata(rdata),
    .zcd_always_on(zcd_always_on),
    .off(off),
    .sfr(sfr),
    .gate(gate)
  );

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  function automatic mdb_byte_t wmask(input int k);
    case (k)
      0: return 8'h7F;
      4: return 8'h07;
      default: return 8'hFF;
    endcase
  endfunction : wmask

  function automatic mdb_byte_t rd_model(input mdb_addr_t a);
    if (a >= 12'h064 && a <= 12'h068) return m[a - 12'h064];
    return 8'h00;
  endfunction : rd_model

  function automatic mdb_off_t exp_off();
    mdb_off_t o;
    o.zero_cross_off = m[0][6] & ~zcd_always_on;
    o.signal_measure_timer_off = m[0][5];
    o.timer_n_off = m[0][4:0];
    {o.capture_compare_off, o.waveform_gen_off, o.signal_modulator_off, o.num_ctrl_osc_off,
     o.clock_tuning_off, o.converter_a_off, o.adc_off, o.comparator_two_off} = m[1];
    {o.serial_port_n_off, o.spi_two_off, o.spi_one_off, o.i2c_one_off,
     o.pulse_mod_three_off, o.pulse_mod_two_off, o.pulse_mod_one_off} = m[2];
    {o.dma_channel_n_off[2:0], o.logic_cell_n_off, o.serial_port_three_off} = m[3];
    {o.op_amp_off, o.converter_b_off, o.dma_channel_n_off[3]} = m[4][2:0];
    return o;
  endfunction : exp_off

  // disable level per peripheral index, zero-cross taken after the configuration override
  function automatic logic [33:0] exp_v();
    return {m[4][2:0], m[3], m[2], m[1], m[0][6] & ~zcd_always_on, m[0][5:0]};
  endfunction : exp_v

  function automatic mdb_gate_t exp_gate(input int i);
    mdb_gate_t g;
    logic [33:0] v;
    v = exp_v();
    g.rst = pv[i];
    g.out_en = ~v[i];
    g.we = sfr[i].we & ~v[i] & ~pv[i];
    g.rdata = (v[i] | pv[i]) ? 8'h00 : sfr[i].rdata;
    return g;
  endfunction : exp_gate

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic bus(input logic w, input logic r, input mdb_addr_t a, input mdb_byte_t d);
    @(posedge mclk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
  endtask : bus

  // mirror takes requests on the same edge as the bank
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 5; k++) m[k] <= 8'h00;
      exp_rd <= 8'h00;
      pv <= '1;
      pv2 <= '1;
    end else begin
      pv <= exp_v();
      pv2 <= pv;
      exp_rd <= req.rd ? rd_model(req.addr) : 8'h00;
      if (req.wr && req.addr >= 12'h064 && req.addr <= 12'h068) begin
        m[req.addr - 12'h064] <= req.wdata & wmask(req.addr - 12'h064);
      end
    end
  end

  // random peripheral-side register traffic every cycle, writes held off just after a re-enable
  always @(posedge mclk) begin : drv_sfr
    logic [33:0] ev;
    ev = exp_v();
    for (int i = 0; i < 34; i++) begin
      s_sfr = lfsr(s_sfr);
      sfr[i] <= {s_sfr[0] & (ev[i] | ~(pv[i] | pv2[i])), s_sfr[8:1]};
    end
  end

  always @(negedge mclk) begin
    check(rdata, exp_rd);
    check(off, exp_off());
    for (int i = 0; i < 34; i++) begin
      check(gate[i], exp_gate(i));
    end
  end

  initial begin
    #400000;
    error_cnt++;
    test_done();
  end

  initial begin
    error_cnt = 0;
    n_tests = 0;
    s = 16'h0022;
    rst = 1'b1;
    req = '0;
    zcd_always_on = 1'b0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    // reset values, unmapped neighbours included
    for (int a = 12'h063; a <= 12'h069; a++) bus(1'b0, 1'b1, a, 8'h00);
    // all ones back to back, then read back through the masks
    for (int a = 12'h064; a <= 12'h068; a++) bus(1'b1, 1'b0, a, 8'hFF);
    for (int a = 12'h063; a <= 12'h069; a++) bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 12'h000, 8'h00);
    zcd_always_on <= 1'b1;
    bus(1'b0, 1'b0, 12'h000, 8'h00);
    for (int a = 12'h064; a <= 12'h068; a++) bus(1'b1, 1'b0, a, 8'h00);
    bus(1'b0, 1'b0, 12'h000, 8'h00);
    // random writes, reads and idles, half of them around the bank
    for (int k = 0; k < 600; k++) begin
      s = lfsr(s);
      s = lfsr(s);
      s = lfsr(s);
      bus(s[1:0] == 2'h1, s[1:0] == 2'h2, s[4] ? {s[15:8], s[3:0]} : 12'h063 + s[7:5], s[15:8]);
      if (s[3:2] == 2'h3) zcd_always_on <= s[9];
    end
    // system reset in mid-run clears every bit
    for (int a = 12'h064; a <= 12'h068; a++) bus(1'b1, 1'b0, a, 8'hFF);
    bus(1'b0, 1'b0, 12'h000, 8'h00);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 12'h064; a <= 12'h068; a++) bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 12'h000, 8'h00);
    repeat (3) @(posedge mclk);
    test_done();
  end

endmodule : tb_mdb_bank
